// *** rtl/acc_params.svh ***
/*
  Constants of the comparator control block: register offsets, field
  positions and reset values.
  Assumes inclusion by bare name from acc_pkg.sv and acc_top.sv.
*/
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ACC_OFS_CTRL_STATUS   8'h00
`define ACC_OFS_DIG_IN_OFF    8'h04
`define ACC_OFS_CONV_CTRL_B   8'h08

// ----------------------------------------------------------------
// Comparator control and status fields
// ----------------------------------------------------------------
`define ACC_BIT_POWER_OFF     7
`define ACC_BIT_REF_SEL       6
`define ACC_BIT_RESULT        5
`define ACC_BIT_FLAG          4
`define ACC_BIT_IRQ_EN        3
`define ACC_BIT_RESERVED      2
`define ACC_BIT_EVT_HI        1
`define ACC_BIT_EVT_LO        0

// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define ACC_BIT_MUX_EN        6
`define ACC_BIT_NEG_IN_OFF    1
`define ACC_BIT_POS_IN_OFF    0
`define ACC_DIG_IN_OFF_W      6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_RST_EVT_SEL       2'h0
`define ACC_RST_DIG_IN_OFF    6'h00

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
// Edges after reset before the previous sample is a real one
`define ACC_SYNC_SETTLE       2'h3

`endif

// *** rtl/acc_pkg.sv ***
/*
  Types of the comparator control block.
  Assumes acc_params.svh is on the include path.
*/
`include "acc_params.svh"

package acc_pkg;

  // ----------------------------------------------------------------
  // Event selection codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_EVT_TOGGLE  = 2'h0,
    ACC_EVT_RSVD    = 2'h1,
    ACC_EVT_FALLING = 2'h2,
    ACC_EVT_RISING  = 2'h3
  } acc_evt_e;

  // ----------------------------------------------------------------
  // Negative input routing to the analog core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       use_channel;
    logic [1:0] channel;
  } acc_neg_sel_s;

  // ----------------------------------------------------------------
  // Whole block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                            sync1;
    logic                            result;
    logic                            prev;
    logic [1:0]                      settle;
    logic                            power_off;
    logic                            ref_sel;
    logic                            flag;
    logic                            irq_en;
    acc_evt_e                        evt_sel;
    logic                            mux_en;
    logic [`ACC_DIG_IN_OFF_W-1:0]    dig_in_off;
    logic                            wr_pend;
    logic [7:0]                      wr_addr;
    logic [31:0]                     hrdata;
    logic                            hreadyout;
    logic                            hresp;
    logic                            irq;
    acc_neg_sel_s                    neg_sel;
    logic                            pos_read;
    logic                            neg_read;
    logic                            pos_buf_en;
    logic                            neg_buf_en;
  } acc_state_s;

endpackage

// *** rtl/acc_top.sv ***
/*
  Comparator control block: result synchroniser, event detection and
  interrupt flag, input routing, pin input disables, AHB-Lite registers.
  Assumes a single clock, an AHB-Lite master with single word transfers,
  and an analog core that follows the power, reference and routing
  outputs.
*/
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`include "acc_params.svh"

module acc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Analog comparator core
  input  wire logic                 cmp_raw,
  output logic                      cmp_power_off,
  output logic                      cmp_internal_ref_sel,
  output acc_pkg::acc_neg_sel_s     cmp_neg_sel,
  // Converter and processor status
  input  wire logic                 converter_on,
  input  wire logic [1:0]           channel_sel_low,
  input  wire logic                 global_irq_enable,
  input  wire logic                 irq_vector_ack,
  output logic                      cmp_irq,
  // Comparator pins, digital side
  input  wire logic                 pos_pin_in,
  input  wire logic                 neg_pin_in,
  output logic                      pos_pin_read,
  output logic                      neg_pin_read,
  output logic                      pos_pin_buf_en,
  output logic                      neg_pin_buf_en
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_chk
    $error("acc_top: ADDR_W must be 4 to 32");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Low byte of the word-aligned address
  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    wide[ADDR_W-1:0] = a;
    return {wide[7:2], 2'b00};
  endfunction

  // True when the synchronised result shows the selected event
  function automatic logic evt_hit(input acc_pkg::acc_evt_e sel,
                                   input logic cur,
                                   input logic old);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      acc_pkg::ACC_EVT_TOGGLE:  hit = cur ^ old;
      acc_pkg::ACC_EVT_RSVD:    hit = 1'b0;
      acc_pkg::ACC_EVT_FALLING: hit = old & ~cur;
      acc_pkg::ACC_EVT_RISING:  hit = cur & ~old;
    endcase
    return hit;
  endfunction

  // Read value of a register from a given state
  function automatic logic [31:0] rd_word(input logic [7:0] ofs,
                                          input acc_pkg::acc_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (ofs)
      `ACC_OFS_CTRL_STATUS: begin
        w[`ACC_BIT_POWER_OFF] = s.power_off;
        w[`ACC_BIT_REF_SEL]   = s.ref_sel;
        w[`ACC_BIT_RESULT]    = s.result;
        w[`ACC_BIT_FLAG]      = s.flag;
        w[`ACC_BIT_IRQ_EN]    = s.irq_en;
        w[`ACC_BIT_RESERVED]  = 1'b0;
        w[`ACC_BIT_EVT_HI:`ACC_BIT_EVT_LO] = s.evt_sel;
      end
      `ACC_OFS_DIG_IN_OFF: begin
        w[`ACC_DIG_IN_OFF_W-1:0] = s.dig_in_off;
      end
      `ACC_OFS_CONV_CTRL_B: begin
        w[`ACC_BIT_MUX_EN] = s.mux_en;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acc_pkg::acc_state_s st_q;
  acc_pkg::acc_state_s st_d;

  logic        addr_ok;
  logic        wr_flag_clr;
  logic        evt;
  logic [7:0]  acc_ofs;

  always_comb begin
    st_d        = st_q;
    acc_ofs     = word_ofs(haddr);
    addr_ok     = hsel && htrans[1] && hready;
    wr_flag_clr = 1'b0;

    // ----------------------------------------------------------------
    // Result synchroniser and edge detection
    // ----------------------------------------------------------------
    st_d.sync1  = cmp_raw;
    st_d.result = st_q.sync1;
    st_d.prev   = st_q.result;
    // No edge until prev holds a real sample, so reset makes no false event
    if (st_q.settle != `ACC_SYNC_SETTLE) begin
      st_d.settle = st_q.settle + 2'h1;
    end
    evt         = (st_q.settle == `ACC_SYNC_SETTLE) &&
                  evt_hit(st_q.evt_sel, st_q.result, st_q.prev);

    // ----------------------------------------------------------------
    // Register writes, data phase of the previous address phase
    // ----------------------------------------------------------------
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        `ACC_OFS_CTRL_STATUS: begin
          st_d.power_off = hwdata[`ACC_BIT_POWER_OFF];
          st_d.ref_sel   = hwdata[`ACC_BIT_REF_SEL];
          st_d.irq_en    = hwdata[`ACC_BIT_IRQ_EN];
          st_d.evt_sel   = acc_pkg::acc_evt_e'(
                             hwdata[`ACC_BIT_EVT_HI:`ACC_BIT_EVT_LO]);
          wr_flag_clr    = hwdata[`ACC_BIT_FLAG];
        end
        `ACC_OFS_DIG_IN_OFF: begin
          st_d.dig_in_off = hwdata[`ACC_DIG_IN_OFF_W-1:0];
        end
        `ACC_OFS_CONV_CTRL_B: begin
          st_d.mux_en = hwdata[`ACC_BIT_MUX_EN];
        end
        default: begin
          st_d.mux_en = st_q.mux_en;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Interrupt flag: set wins over both clears
    // ----------------------------------------------------------------
    if (wr_flag_clr || irq_vector_ack) begin
      st_d.flag = 1'b0;
    end
    if (evt) begin
      st_d.flag = 1'b1;
    end
    st_d.irq = st_d.flag && st_d.irq_en && global_irq_enable;

    // ----------------------------------------------------------------
    // Bus address phase
    // ----------------------------------------------------------------
    st_d.wr_pend   = addr_ok && hwrite;
    st_d.wr_addr   = acc_ofs;
    st_d.hreadyout = 1'b1;
    st_d.hresp     = 1'b0;
    if (addr_ok && !hwrite) begin
      st_d.hrdata = rd_word(acc_ofs, st_d);
    end

    // ----------------------------------------------------------------
    // Input routing and pin buffers
    // ----------------------------------------------------------------
    st_d.neg_sel.use_channel = st_d.mux_en && !converter_on;
    st_d.neg_sel.channel     = channel_sel_low;
    st_d.pos_read = pos_pin_in && !st_d.dig_in_off[`ACC_BIT_POS_IN_OFF];
    st_d.neg_read = neg_pin_in && !st_d.dig_in_off[`ACC_BIT_NEG_IN_OFF];
    st_d.pos_buf_en = !st_d.dig_in_off[`ACC_BIT_POS_IN_OFF];
    st_d.neg_buf_en = !st_d.dig_in_off[`ACC_BIT_NEG_IN_OFF];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{
        sync1:      1'b0,
        result:     1'b0,
        prev:       1'b0,
        settle:     2'h0,
        power_off:  1'b0,
        ref_sel:    1'b0,
        flag:       1'b0,
        irq_en:     1'b0,
        evt_sel:    acc_pkg::acc_evt_e'(`ACC_RST_EVT_SEL),
        mux_en:     1'b0,
        dig_in_off: `ACC_RST_DIG_IN_OFF,
        wr_pend:    1'b0,
        wr_addr:    8'h00,
        hrdata:     32'h0000_0000,
        hreadyout:  1'b1,
        hresp:      1'b0,
        irq:        1'b0,
        neg_sel:    '{use_channel: 1'b0, channel: 2'h0},
        pos_read:   1'b0,
        neg_read:   1'b0,
        pos_buf_en: 1'b1,
        neg_buf_en: 1'b1
      };
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata               = st_q.hrdata;
  assign hreadyout            = st_q.hreadyout;
  assign hresp                = st_q.hresp;
  assign cmp_power_off        = st_q.power_off;
  assign cmp_internal_ref_sel = st_q.ref_sel;
  assign cmp_neg_sel          = st_q.neg_sel;
  assign cmp_irq              = st_q.irq;
  assign pos_pin_read         = st_q.pos_read;
  assign neg_pin_read         = st_q.neg_read;
  assign pos_pin_buf_en       = st_q.pos_buf_en;
  assign neg_pin_buf_en       = st_q.neg_buf_en;

endmodule

// *** verification/acc_partner.sv ***
/*
  Behavioural analog comparator core with its input routing.
  Assumes levels in millivolts from the bench, controls from acc_top.
*/
`timescale 1ns/1ns
module acc_partner (
  // Controls from the block
  input  wire logic             power_off,
  input  wire logic             ref_sel,
  input  acc_pkg::acc_neg_sel_s neg_sel,
  // Analog levels
  input  int                    pos_mv,
  input  int                    neg_mv,
  input  int                    ref_mv,
  input  int                    ch_mv [4],
  // Comparator output
  output logic                  raw
);
  int plus_mv;
  int minus_mv;
  always_comb begin
    plus_mv = ref_sel ? ref_mv : pos_mv;
    minus_mv = neg_sel.use_channel ? ch_mv[neg_sel.channel] : neg_mv;
    raw = !power_off && plus_mv > minus_mv;
  end
endmodule

// *** verification/acc_top_asserts.sv ***
/*
  Port checker of the comparator control block.
  Assumes a bind to acc_top, one clock domain, rst_n async low.
*/
`timescale 1ns/1ns
module acc_top_asserts #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, bus
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Comparator and pins
  input wire logic              cmp_raw,
  input wire logic              cmp_power_off,
  input wire logic              cmp_internal_ref_sel,
  input acc_pkg::acc_neg_sel_s  cmp_neg_sel,
  input wire logic              converter_on,
  input wire logic [1:0]        channel_sel_low,
  input wire logic              global_irq_enable,
  input wire logic              irq_vector_ack,
  input wire logic              cmp_irq,
  input wire logic              pos_pin_in,
  input wire logic              pos_pin_read,
  input wire logic              pos_pin_buf_en
);
  logic ctl_wr_q;
  // Data phase of a control register write
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ctl_wr_q <= 1'b0;
    else
      ctl_wr_q <= hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
  chk_ctl_write: assert property (
    ctl_wr_q |=> {cmp_power_off, cmp_internal_ref_sel} == $past(hwdata[7:6]))
    else $error("control bits not written");
  chk_ctl_hold: assert property (
    $changed({cmp_power_off, cmp_internal_ref_sel}) |-> $past(ctl_wr_q))
    else $error("control bits changed alone");
  chk_irq_global: assert property (cmp_irq |-> $past(global_irq_enable))
    else $error("request without global enable");
  chk_irq_mask: assert property (ctl_wr_q && !hwdata[3] |=> !cmp_irq)
    else $error("request while masked");
  chk_ack_clear: assert property (
    irq_vector_ack && $past(cmp_raw, 2) == $past(cmp_raw, 3) |=> !cmp_irq)
    else $error("vector entry left request");
  chk_route_off: assert property (converter_on |=> !cmp_neg_sel.use_channel)
    else $error("channel routed while converter on");
  chk_route_chan: assert property (
    cmp_neg_sel.use_channel |-> cmp_neg_sel.channel == $past(channel_sel_low))
    else $error("wrong channel routed");
  chk_pin_read: assert property (
    pos_pin_read |-> pos_pin_buf_en && $past(pos_pin_in))
    else $error("pin read through disabled buffer");
  cov_irq: cover property ($rose(cmp_irq));
  cov_ack: cover property (irq_vector_ack && cmp_irq);
  cov_route: cover property (cmp_neg_sel.use_channel);
endmodule

bind acc_top acc_top_asserts #(.ADDR_W(ADDR_W)) i_acc_top_asserts (
  .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .cmp_raw, .cmp_power_off, .cmp_internal_ref_sel, .cmp_neg_sel,
  .converter_on, .channel_sel_low, .global_irq_enable, .irq_vector_ack,
  .cmp_irq, .pos_pin_in, .pos_pin_read, .pos_pin_buf_en
);

// *** verification/test_analog_comparator_control.sv ***
/*
  Self-checking bench of acc_top with a comparator model.
  Assumes acc_pkg, acc_partner and the checker compiled before it.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t: got %0h exp %0h", $time, a, e); end end
module test_analog_comparator_control;
  logic                  clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]            haddr = 8'h00;
  logic [1:0]            htrans = 2'h0, channel_sel_low = 2'h0;
  logic [31:0]           hwdata = '0, hrdata, rdat;
  logic                  hreadyout, hresp, cmp_raw, cmp_power_off, cmp_internal_ref_sel;
  logic                  converter_on = 1'b0, global_irq_enable = 1'b0, irq_vector_ack = 1'b0;
  logic                  pos_pin_in = 1'b0, neg_pin_in = 1'b0, cmp_irq;
  logic                  pos_pin_read, neg_pin_read, pos_pin_buf_en, neg_pin_buf_en;
  acc_pkg::acc_neg_sel_s cmp_neg_sel;
  int                    pos_mv = 100, neg_mv = 200, ref_mv = 500;
  int                    ch_mv [4] = '{400, 400, 50, 400};
  int                    fail_count = 0, num_checks = 0, cycles = 0;
  acc_top i_acc_top (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmp_raw, .cmp_power_off,
    .cmp_internal_ref_sel, .cmp_neg_sel, .converter_on, .channel_sel_low,
    .global_irq_enable, .irq_vector_ack, .cmp_irq, .pos_pin_in, .neg_pin_in,
    .pos_pin_read, .neg_pin_read, .pos_pin_buf_en, .neg_pin_buf_en
  );
  acc_partner i_acc_partner (
    .power_off(cmp_power_off), .ref_sel(cmp_internal_ref_sel), .neg_sel(cmp_neg_sel),
    .pos_mv, .neg_mv, .ref_mv, .ch_mv, .raw(cmp_raw)
  );
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    @(negedge clk);
  endtask
  task automatic t_regs();
    bus(1'b1, 8'h00, 32'hFFFF_FFEF);
    bus(1'b0, 8'h00, '0);
    `CHK(rdat, 32'h0000_00CB)
    `CHK({cmp_power_off, cmp_internal_ref_sel}, 2'h3)
    bus(1'b1, 8'h00, 32'h0000_00C3);
    for (int a = 0; a < 16; a += 4)
      bus(1'b1, 8'(a), a == 0 ? 32'h0000_0000 : 32'hFFFF_FFFF);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 8'(a), '0);
      `CHK(rdat, a == 4 ? 32'h0000_003F : a == 8 ? 32'h0000_0040 : 32'h0)
    end
    bus(1'b1, 8'h04, '0);
    bus(1'b1, 8'h08, '0);
    $display("registers done");
  endtask
  task automatic t_events();
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h00, 32'(16 + m));
      @(posedge clk);
      pos_mv <= 300;
      repeat (6) @(negedge clk);
      bus(1'b0, 8'h00, '0);
      `CHK(rdat[5:4], {1'b1, m == 0 || m == 3})
      bus(1'b1, 8'h00, 32'(16 + m));
      @(posedge clk);
      pos_mv <= 100;
      repeat (6) @(negedge clk);
      bus(1'b0, 8'h00, '0);
      `CHK(rdat[5:4], {1'b0, m == 0 || m == 2})
    end
    $display("events done");
  endtask
  task automatic t_irq();
    bus(1'b1, 8'h00, 32'h0000_001B);
    @(posedge clk);
    pos_mv <= 300;
    repeat (6) @(negedge clk);
    `CHK(cmp_irq, 1'b0)
    @(posedge clk);
    global_irq_enable <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK(cmp_irq, 1'b1)
    @(posedge clk);
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    @(negedge clk);
    `CHK(cmp_irq, 1'b0)
    @(posedge clk);
    pos_mv <= 100;
    repeat (6) @(negedge clk);
    `CHK(cmp_irq, 1'b0)
    @(posedge clk);
    pos_mv <= 300;
    repeat (6) @(negedge clk);
    bus(1'b1, 8'h00, 32'h0000_000B);
    `CHK(cmp_irq, 1'b1)
    bus(1'b1, 8'h00, 32'h0000_0003);
    `CHK(cmp_irq, 1'b0)
    bus(1'b1, 8'h00, 32'h0000_0013);
    bus(1'b0, 8'h00, '0);
    `CHK(rdat, 32'h0000_0023)
    $display("interrupt done");
  endtask
  task automatic t_route();
    @(posedge clk);
    pos_mv <= 100;
    bus(1'b1, 8'h08, 32'h0000_0040);
    for (int c = 0; c < 5; c++) begin
      @(posedge clk);
      channel_sel_low <= 2'(c);
      converter_on <= c == 4;
      repeat (6) @(negedge clk);
      bus(1'b0, 8'h00, '0);
      `CHK({cmp_neg_sel, rdat[5]}, {c < 4, 2'(c), c == 2})
    end
    bus(1'b1, 8'h08, '0);
    $display("routing done");
  endtask
  task automatic t_pins();
    @(posedge clk);
    pos_pin_in <= 1'b1;
    neg_pin_in <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, 8'h04, 32'(d));
      `CHK({pos_pin_read, pos_pin_buf_en, neg_pin_read, neg_pin_buf_en}, {{2{d % 2 == 0}}, {2{d < 2}}})
    end
    bus(1'b1, 8'h04, '0);
    `CHK(pos_pin_read, 1'b1)
    @(posedge clk);
    pos_pin_in <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(pos_pin_read, 1'b0)
    $display("pins done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_irq();
    t_route();
    t_pins();
    final_report();
  end
endmodule
